// File: src/ca_decode.sv
// Header capture, decode and read-data placement for an octal DDR pseudo-static DRAM slave.
//
// Contract
// - Six header bytes arrive on the first six clock edges; all captured.
// - Bytes descend from bits 47..40 to 7..0, bit 7 on line 7.
// - Header bit 47 high means read, low means write.
// - Header bit 46 low selects memory, high selects register space.
// - Header bit 45 low selects wrapped burst, high selects linear.
// - Header bits 44..16 become word address bits 31..3.
// - Header bits 15..3 are reserved and ignored by the device.
// - Header bits 2..0 become word address bits 2..0.
// - Upper column picks an eight-word half-page; lower picks start word.
// - Read access timing starts once row and upper column are captured.
// - Linear reads interleave accesses to successive half-pages.
// - Memory-space bytes return in the order they were written.
// - Register-space words travel most significant byte first.
// - During reads the strobe is driven, data edge-aligned to it.
// - Data always moves in whole 16-bit words.
// - Word address advances per cycle; byte A high strobe, B low.
// - Each address selects one 16-bit word, up to 4G words.
// - Chip select rising ends the transaction; device abandons it.
// - During header the strobe signals extra latency high, none low.
`timescale 1ns/1ns
`default_nettype none

module ca_decode #(
	parameter int DATA_W = 8
) (
	// Core clock and synchronous reset.
	input  wire logic                                 core_clk,
	input  wire logic                                 sys_rst,
	// Bus pins from the host, asynchronous to core_clk.
	input  wire logic                                 cs_n_pin,
	input  wire logic                                 bus_clock,
	input  wire logic [DATA_W-1:0]                    dq_in,
	input  wire logic                                 rw_data_strobe_in,
	// Bus pins driven by the device; enables are low while driving.
	output logic      [DATA_W-1:0]                    dq_out,
	output logic                                      dq_oe_n,
	output logic                                      rw_data_strobe_out,
	output logic                                      rw_data_strobe_oe_n,
	// Latency request and read data from the core.
	input  wire logic                                 extra_latency,
	input  wire logic                                 rd_valid,
	input  wire logic [2*DATA_W-1:0]                  rd_word,
	// Decoded header and transaction status.
	output ca_decode_pkg::hdr_s                       hdr,
	output logic                                      hdr_valid,
	output logic                                      access_start,
	output logic      [ca_decode_pkg::UPPER_W-1:0]    access_page,
	output logic                                      next_page_req,
	output logic      [ca_decode_pkg::UPPER_W-1:0]    next_page,
	output logic                                      rd_taken,
	output logic      [ca_decode_pkg::ADDR_W-1:0]     cur_addr,
	output logic                                      wr_byte_valid,
	output logic      [DATA_W-1:0]                    wr_byte,
	output logic                                      wr_byte_mask,
	output logic                                      txn_abort
);

	// Two-stage synchronisers; first stages are read only by second stages.
	logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;
	logic              cs_s1_ff, cs_s2_ff, cs_s3_ff;
	logic              ck_s1_ff, ck_s2_ff, ck_s3_ff;
	logic              ds_s1_ff, ds_s2_ff;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dq_s1_ff <= '0;
			dq_s2_ff <= '0;
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			cs_s3_ff <= 1'b1;
			ck_s1_ff <= 1'b0;
			ck_s2_ff <= 1'b0;
			ck_s3_ff <= 1'b0;
			ds_s1_ff <= 1'b0;
			ds_s2_ff <= 1'b0;
		end else begin
			dq_s1_ff <= dq_in;
			dq_s2_ff <= dq_s1_ff;
			cs_s1_ff <= cs_n_pin;
			cs_s2_ff <= cs_s1_ff;
			cs_s3_ff <= cs_s2_ff;
			ck_s1_ff <= bus_clock;
			ck_s2_ff <= ck_s1_ff;
			ck_s3_ff <= ck_s2_ff;
			ds_s1_ff <= rw_data_strobe_in;
			ds_s2_ff <= ds_s1_ff;
		end
	end

	// Edge detection on the synchronised pins. Both clock edges carry data.
	// The bus clock complement is redundant for a sampled design and is not used.
	wire cs_fall  = cs_s3_ff & ~cs_s2_ff;
	wire cs_rise  = ~cs_s3_ff & cs_s2_ff;
	wire cs_low   = ~cs_s2_ff;
	wire ck_rise  = ~ck_s3_ff & ck_s2_ff;
	wire ck_fall  = ck_s3_ff & ~ck_s2_ff;
	wire ck_edge  = ck_rise | ck_fall;

	// State and header registers.
	ca_decode_pkg::rx_state_e state_ff, nxt_state;
	logic [ca_decode_pkg::CNT_W-1:0]    cnt_ff;
	logic [ca_decode_pkg::HDR_BITS-1:0] shift_ff;
	logic                               byte_b_ff;
	logic [ca_decode_pkg::UPPER_W-1:0]  page_ff;
	logic [ca_decode_pkg::LOWER_W-1:0]  word_ff;

	// Header assembled so far, newest byte in the low bits.
	wire [ca_decode_pkg::HDR_BITS-1:0] shift_next = {shift_ff[ca_decode_pkg::HDR_BITS-
		ca_decode_pkg::BYTE_BITS-1:0], dq_s2_ff};
	wire hdr_edge   = (state_ff == ca_decode_pkg::ST_HDR) && ck_edge && cs_low;
	wire hdr_last   = hdr_edge && (cnt_ff == ca_decode_pkg::LAST_IDX);
	wire upper_seen = hdr_edge && (cnt_ff == ca_decode_pkg::UPPER_DONE_IDX);
	wire in_data    = (state_ff == ca_decode_pkg::ST_DATA) && cs_low;
	wire data_edge  = in_data && ck_edge;

	// Field decode of the complete header; reserved bits 15..3 are dropped.
	wire                              dec_read   = shift_next[ca_decode_pkg::POS_DIR];
	wire                              dec_space  = shift_next[ca_decode_pkg::POS_SPACE];
	wire                              dec_linear = shift_next[ca_decode_pkg::POS_BURST];
	wire [ca_decode_pkg::UPPER_W-1:0] dec_upper  =
		shift_next[ca_decode_pkg::POS_UPPER_HI:ca_decode_pkg::POS_UPPER_LO];
	wire [ca_decode_pkg::LOWER_W-1:0] dec_lower  =
		shift_next[ca_decode_pkg::POS_LOWER_HI:ca_decode_pkg::POS_LOWER_LO];
	// Row and upper column known after the fourth edge: bits 44..16 sit at 28..0 then.
	wire [ca_decode_pkg::UPPER_W-1:0] early_upper =
		shift_next[ca_decode_pkg::POS_UPPER_HI-ca_decode_pkg::POS_UPPER_LO:0];

	// Word stepping; the half-page wraps in wrapped mode and rolls over in linear mode.
	wire                              word_wrap  = (word_ff == {ca_decode_pkg::LOWER_W{1'b1}});
	wire                              step_word  = data_edge && byte_b_ff;
	wire [ca_decode_pkg::LOWER_W-1:0] word_inc   = word_ff + ca_decode_pkg::LOWER_ONE;
	wire                              page_roll  = step_word && word_wrap && hdr.linear;
	wire [ca_decode_pkg::UPPER_W-1:0] page_inc   = page_ff + ca_decode_pkg::UPPER_ONE;

	// Read placement: byte A is the word's high byte, so register words go MSB first.
	// Memory words follow the same lane order in both directions, which keeps whatever
	// order the host wrote.
	wire [DATA_W-1:0] rd_byte = byte_b_ff ? rd_word[DATA_W-1:0]
		: rd_word[2*DATA_W-1:DATA_W];
	wire              rd_drive = in_data && hdr.is_read && rd_valid;

	// Next-state decode.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ca_decode_pkg::ST_IDLE: begin
				if (cs_fall && !ck_s2_ff) begin
					nxt_state = ca_decode_pkg::ST_HDR;
				end
			end
			ca_decode_pkg::ST_HDR: begin
				if (hdr_last) begin
					nxt_state = ca_decode_pkg::ST_DATA;
				end
			end
			ca_decode_pkg::ST_DATA: nxt_state = ca_decode_pkg::ST_DATA;
			ca_decode_pkg::ST_DONE: nxt_state = ca_decode_pkg::ST_IDLE;
			default: nxt_state = ca_decode_pkg::ST_IDLE;
		endcase
		if (cs_rise) begin
			nxt_state = ca_decode_pkg::ST_DONE;
		end
	end

	// Sequencer, header shift register and burst address.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_ff  <= ca_decode_pkg::ST_IDLE;
			cnt_ff    <= ca_decode_pkg::CNT_ZERO;
			shift_ff  <= ca_decode_pkg::HDR_ZERO;
			byte_b_ff <= 1'b0;
			page_ff   <= '0;
			word_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state == ca_decode_pkg::ST_HDR && state_ff == ca_decode_pkg::ST_IDLE) begin
				cnt_ff    <= ca_decode_pkg::CNT_ZERO;
				byte_b_ff <= 1'b0;
			end else if (hdr_edge) begin
				cnt_ff   <= cnt_ff + ca_decode_pkg::CNT_ONE;
				shift_ff <= shift_next;
			end
			if (hdr_last) begin
				page_ff <= dec_upper;
				word_ff <= dec_lower;
			end else if (step_word) begin
				word_ff <= word_inc;
				if (page_roll) begin
					page_ff <= page_inc;
				end
			end
			if (data_edge) begin
				byte_b_ff <= ~byte_b_ff;
			end
		end
	end

	// Decoded header, status pulses and write capture toward the core.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hdr           <= '0;
			hdr_valid     <= 1'b0;
			access_start  <= 1'b0;
			access_page   <= '0;
			next_page_req <= 1'b0;
			next_page     <= '0;
			rd_taken      <= 1'b0;
			cur_addr      <= '0;
			wr_byte_valid <= 1'b0;
			wr_byte       <= '0;
			wr_byte_mask  <= 1'b0;
			txn_abort     <= 1'b0;
		end else begin
			if (hdr_last) begin
				hdr <= {dec_read, dec_space, dec_linear, dec_upper, dec_lower};
			end
			hdr_valid     <= (hdr_valid | hdr_last) & ~cs_rise;
			access_start  <= upper_seen;
			if (upper_seen) begin
				access_page <= early_upper;
			end
			next_page_req <= (hdr_last && dec_linear) || page_roll;
			next_page     <= hdr_last ? dec_upper + ca_decode_pkg::UPPER_ONE
				: page_inc + ca_decode_pkg::UPPER_ONE;
			rd_taken      <= rd_drive && step_word;
			cur_addr      <= {page_ff, word_ff};
			wr_byte_valid <= data_edge && !hdr.is_read;
			wr_byte       <= dq_s2_ff;
			wr_byte_mask  <= ds_s2_ff;
			txn_abort     <= cs_rise && (state_ff != ca_decode_pkg::ST_IDLE);
		end
	end

	// Pin drivers; the strobe follows the bus clock during reads so data is edge-aligned.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dq_out              <= '0;
			dq_oe_n             <= 1'b1;
			rw_data_strobe_out  <= 1'b0;
			rw_data_strobe_oe_n <= 1'b1;
		end else begin
			dq_out  <= rd_byte;
			dq_oe_n <= ~rd_drive;
			if (cs_s2_ff) begin
				rw_data_strobe_out  <= 1'b0;
				rw_data_strobe_oe_n <= 1'b1;
			end else if (state_ff == ca_decode_pkg::ST_HDR && !hdr_last) begin
				// Let go on the last header edge, so a write never meets the host's mask.
				rw_data_strobe_out  <= extra_latency;
				rw_data_strobe_oe_n <= 1'b0;
			end else if (rd_drive) begin
				rw_data_strobe_out  <= ~byte_b_ff;
				rw_data_strobe_oe_n <= 1'b0;
			end else begin
				rw_data_strobe_out  <= 1'b0;
				rw_data_strobe_oe_n <= ~(in_data && hdr.is_read);
			end
		end
	end

endmodule

`default_nettype wire

// File: inc/ca_decode_pkg.sv
// Package with header layout, field positions and carrier types for the header decoder.
package ca_decode_pkg;

	// Header geometry.
	localparam int HDR_BYTES    = 6;
	localparam int HDR_BITS     = 48;
	localparam int BYTE_BITS    = 8;
	localparam int CNT_W        = 3;

	// Field positions inside the 48-bit header.
	localparam int POS_DIR      = 47;
	localparam int POS_SPACE    = 46;
	localparam int POS_BURST    = 45;
	localparam int POS_UPPER_HI = 44;
	localparam int POS_UPPER_LO = 16;
	localparam int POS_LOWER_HI = 2;
	localparam int POS_LOWER_LO = 0;

	// Word address layout.
	localparam int ADDR_W       = 32;
	localparam int UPPER_W      = 29;
	localparam int LOWER_W      = 3;

	// Edge index after which row and upper column are known (fourth edge, index 3).
	localparam logic [CNT_W-1:0] UPPER_DONE_IDX = 3'h3;
	localparam logic [CNT_W-1:0] LAST_IDX       = 3'h5;
	localparam logic [CNT_W-1:0] CNT_ZERO       = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE        = 3'h1;
	localparam logic [HDR_BITS-1:0] HDR_ZERO    = 48'h0;
	localparam logic [LOWER_W-1:0] LOWER_ONE    = 3'h1;
	localparam logic [UPPER_W-1:0] UPPER_ONE    = 29'h1;

	// Decoded header carried to the user side.
	typedef struct packed {
		logic                is_read;
		logic                reg_space;
		logic                linear;
		logic [ADDR_W-1:0]   word_addr;
	} hdr_s;

	// Receive state machine.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HDR  = 2'b01,
		ST_DATA = 2'b10,
		ST_DONE = 2'b11
	} rx_state_e;

endpackage

// File: testbench/ca_decode_checker.sv
// Concurrent checks on the ports of the header decoder.
`timescale 1ns/1ns
`default_nettype none
module ca_decode_checker (
	// Clock, reset and chip select.
	input wire logic                                core_clk,
	input wire logic                                sys_rst,
	input wire logic                                cs_n_pin,
	// Pin drivers of the device.
	input wire logic                                dq_oe_n,
	input wire logic                                rw_data_strobe_out,
	input wire logic                                rw_data_strobe_oe_n,
	// Decode and status outputs.
	input wire ca_decode_pkg::hdr_s                 hdr,
	input wire logic                                hdr_valid,
	input wire logic                                access_start,
	input wire logic [ca_decode_pkg::UPPER_W-1:0]   access_page,
	input wire logic                                next_page_req,
	input wire logic                                rd_taken,
	input wire logic                                txn_abort
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// Deselect long enough to pass the pin synchronisers.
	sequence s_cs_idle;
		cs_n_pin [*5];
	endsequence
	sequence s_hdr_done;
		$rose(hdr_valid);
	endsequence

	a_idle_floats: assert property (s_cs_idle |-> dq_oe_n && rw_data_strobe_oe_n)
		else $error("drivers on while deselected");
	a_page_early: assert property (s_hdr_done |-> access_page == hdr.word_addr[31:3])
		else $error("early page differs from header");
	a_start_first: assert property (access_start |-> !hdr_valid ##[1:60] s_hdr_done)
		else $error("access start not ahead of header end");
	a_hdr_stable: assert property (hdr_valid && $past(hdr_valid) |-> $stable(hdr))
		else $error("decoded header moved while valid");
	a_write_quiet: assert property (hdr_valid && !hdr.is_read |-> dq_oe_n && rw_data_strobe_oe_n)
		else $error("device drives pins in a write");
	a_strobe_data: assert property (!dq_oe_n |-> !rw_data_strobe_oe_n)
		else $error("read data without strobe");
	a_b_byte_low: assert property (rd_taken |-> ##[0:1] !rw_data_strobe_out)
		else $error("strobe high on byte B");
	a_abort_release: assert property (txn_abort |-> ##[0:2] dq_oe_n && rw_data_strobe_oe_n)
		else $error("drivers stay on after abort");
	a_linear_only: assert property (next_page_req |-> hdr.linear)
		else $error("prefetch in a wrapped burst");
endmodule
`default_nettype wire

// File: testbench/host_model.sv
// Host controller model: chip select, bus clock, header and write data.
`timescale 1ns/1ns
`default_nettype none
module host_model (
	// Pins driven by the host.
	output logic             cs_n_pin,
	output logic             bus_clock,
	output logic [7:0]       dq_in,
	output logic             rw_data_strobe_in,
	// Pins driven by the device.
	input  wire logic [7:0]  dq_out,
	input  wire logic        dq_oe_n,
	input  wire logic        rw_data_strobe_out,
	input  wire logic        rw_data_strobe_oe_n
);
	logic [7:0] host_dq = 8'h5a;
	logic       host_ds = 1'b0;
	// The device wins the wire where it drives; the host byte otherwise.
	assign dq_in = dq_oe_n ? host_dq : dq_out;
	assign rw_data_strobe_in = rw_data_strobe_oe_n ? host_ds : rw_data_strobe_out;
	initial begin
		cs_n_pin = 1'b1;
		bus_clock = 1'b0;
	end
	// One clock edge with the byte centred on it; the clock stands still between frames.
	task automatic edge_out(input logic [7:0] b, input logic m);
		host_dq <= b;
		host_ds <= m;
		#40;
		bus_clock <= ~bus_clock;
		#40;
	endtask
	// Full frame: header, one word of data, then deselect.
	task automatic xfer(input logic [47:0] h, input logic [15:0] wd, input logic [1:0] mk);
		cs_n_pin <= 1'b0;
		#80;
		for (int i = 5; i >= 0; i--)
			edge_out(h[i*8 +: 8], ~host_ds);
		edge_out(wd[15:8], mk[1]);
		edge_out(wd[7:0], mk[0]);
		cs_n_pin <= 1'b1;
		host_dq <= ~host_dq;
		#80;
	endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Top-level bench: host model, decoder, reference checks and checker binding.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic                core_clk = 1'b0;
	logic                sys_rst = 1'b1;
	logic                extra_latency = 1'b0;
	logic                rd_valid = 1'b0;
	logic [15:0]         rd_word = 16'h0;
	logic [15:0]         lfsr_st = 16'h1d2c;
	int                  fails = 0;
	int                  total_checks = 0;
	logic                cs_n_pin, bus_clock, rw_data_strobe_in, dq_oe_n;
	logic                rw_data_strobe_out, rw_data_strobe_oe_n, hdr_valid, access_start;
	logic                next_page_req, rd_taken, wr_byte_valid, wr_byte_mask, txn_abort;
	logic [7:0]          dq_in, dq_out, wr_byte;
	logic [28:0]         access_page, next_page;
	logic [31:0]         cur_addr;
	ca_decode_pkg::hdr_s hdr;
	wire logic [4:0]     evt = {txn_abort, wr_byte_valid, rd_taken, access_start, hdr_valid};

	host_model i_host (.cs_n_pin, .bus_clock, .dq_in, .rw_data_strobe_in, .dq_out, .dq_oe_n,
		.rw_data_strobe_out, .rw_data_strobe_oe_n);
	ca_decode i_ca_decode (.core_clk, .sys_rst, .cs_n_pin, .bus_clock, .dq_in, .rw_data_strobe_in,
		.dq_out, .dq_oe_n, .rw_data_strobe_out, .rw_data_strobe_oe_n, .extra_latency, .rd_valid,
		.rd_word, .hdr, .hdr_valid, .access_start, .access_page, .next_page_req, .next_page,
		.rd_taken, .cur_addr, .wr_byte_valid, .wr_byte, .wr_byte_mask, .txn_abort);

	// Core clock at 250 MHz.
	always #2 core_clk = ~core_clk;

	// Pseudo-random source, so every run drives the same headers.
	function automatic logic [15:0] rnd();
		lfsr_st = {lfsr_st[14:0], lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
		return lfsr_st;
	endfunction

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [63:0] s, input logic [63:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Bounded wait for one status pulse or level; a hang ends the run.
	task automatic wt(input int k);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (evt[k] !== 1'b1 && n < 300);
		if (n >= 300) begin
			cmp("timeout", k, 64'hff);
			end_of_test();
		end
	endtask

	// Reference model of one transaction, run beside the host frame.
	task automatic check_txn(input ca_decode_pkg::hdr_s e, input logic [15:0] wd,
		input logic [1:0] mk);
		logic [31:0] nx;
		nx = e.linear ? e.word_addr + 32'h1 : {e.word_addr[31:3], e.word_addr[2:0] + 3'h1};
		wt(1);
		cmp("latency strobe", {rw_data_strobe_oe_n, rw_data_strobe_out}, {1'b0, extra_latency});
		wt(0);
		cmp("header", hdr, e);
		cmp("prefetch", {next_page_req, next_page},
			{e.linear, e.word_addr[31:3] + 29'h1});
		if (e.is_read) begin
			rd_valid <= 1'b1;
			rd_word <= wd;
			repeat (3) @(posedge core_clk);
			#1;
			cmp("byte A", {dq_oe_n, rw_data_strobe_out, dq_out}, {2'b01, wd[15:8]});
			wt(2);
			rd_valid <= 1'b0;
			cmp("byte B", {rw_data_strobe_out, dq_out}, {1'b0, wd[7:0]});
		end else begin
			wt(3);
			cmp("write A", {wr_byte_mask, wr_byte}, {mk[1], wd[15:8]});
			wt(3);
			cmp("write B", {wr_byte_mask, wr_byte}, {mk[0], wd[7:0]});
		end
		wt(4);
		cmp("next address", cur_addr, nx);
	endtask

	// Every direction, space and burst code once; odd runs start on the last word.
	initial begin
		logic [47:0] h;
		logic [15:0] wd;
		ca_decode_pkg::hdr_s e;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		cmp("idle pins", {dq_oe_n, rw_data_strobe_oe_n, hdr_valid}, 3'b110);
		for (int i = 0; i < 8; i++) begin
			h = {rnd(), rnd(), rnd()};
			h[47:45] = i[2:0];
			if (i[0])
				h[2:0] = 3'h7;
			wd = rnd();
			extra_latency <= wd[4];
			e = '{h[47], h[46], h[45], {h[44:16], h[2:0]}};
			fork
				i_host.xfer(h, wd, wd[1:0] ^ 2'h1);
				check_txn(e, wd, wd[1:0] ^ 2'h1);
			join
			@(posedge core_clk);
		end
		end_of_test();
	end
endmodule

bind ca_decode ca_decode_checker i_ca_decode_checker (.core_clk, .sys_rst, .cs_n_pin, .dq_oe_n,
	.rw_data_strobe_out, .rw_data_strobe_oe_n, .hdr, .hdr_valid, .access_start, .access_page,
	.next_page_req, .rd_taken, .txn_abort);
`default_nettype wire
